// ---- common/acts_pkg.sv ----
package acts_pkg;
   // Master clock
   localparam int CLK_PERIOD_NS   = 50;
   // Busy must rise within 2.5 master periods; sync path gives 2
   localparam int BUSY_LAT_HALVES = 5;
   localparam int BUSY_LAT_CYCLES = BUSY_LAT_HALVES / 2;
   // Lengths in master clock periods
   localparam int CONV_CYCLES     = 18;
   localparam int CAL_SELF_CYCLES = 125013;
   localparam int CAL_FS_CYCLES   = 111114;
   localparam int CAL_OFF_CYCLES  = 13899;
   localparam int CNT_W           = 17;
   // Data path
   localparam int SMP_W           = 12;
   localparam int WORD_W          = 16;
   localparam int BIT_CNT_W       = 5;
   localparam int FRESH_BIT       = 15;
   localparam int FIFO_DEPTH      = 8;
   // Interface modes
   localparam logic [2:0] MODE_TWO_WIRE = 3'h1;
   localparam logic [2:0] MODE_INT_A    = 3'h4;
   localparam logic [2:0] MODE_INT_B    = 3'h5;
   // Calibration types
   localparam logic [1:0] CAL_SELF      = 2'h0;
   localparam logic [1:0] CAL_SYS_FS    = 2'h1;
   localparam logic [1:0] CAL_SYS_OFF   = 2'h2;
   localparam logic [1:0] CAL_SYS_BOTH  = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_CONVERT  = 3'b001,
      ST_CAL_A    = 3'b010,
      ST_CAL_WAIT = 3'b011,
      ST_CAL_B    = 3'b100
   } acts_state_t;
endpackage

// ---- src/acts_fifo.sv ----
`timescale 1ns/1ps
module acts_fifo #(
   parameter int W     = 12,
   parameter int DEPTH = 8
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic         in_valid_in,
   output logic              in_ready_out,
   input  wire logic [W-1:0] in_data_in,
   output logic              out_valid_out,
   input  wire logic         out_ready_in,
   output logic [W-1:0]      out_data_out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0]  mem_q [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [CW-1:0] count_q;
   logic          push;
   logic          pop;

   assign in_ready_out  = (count_q != CW'(DEPTH));
   assign out_valid_out = (count_q != '0);
   assign out_data_out  = mem_q[rd_ptr_q];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule // acts_fifo

// ---- src/acts_core.sv ----
`timescale 1ns/1ps
// Functional notes
// - A conversion keeps busy high for exactly 18 master clock periods.
// - Full self-calibration keeps busy high for 125013 master clock periods.
// - Trim converter plus system full-scale calibration takes 111114 periods.
// - System offset calibration takes 13899 periods before ready again.
// - Busy rises within 2.5 periods of calibration request or start edge; a start refused on a full buffer raises none.
// - Falling edge on conversion start begins conversion and raises busy; the code refuses it while the result buffer is full.
// - Modes 4 and 5 drive the serial clock out at master rate.
// - Data output leaves high impedance after frame select falls, returns after rise; in two-wire mode it stays high impedance.
// - Shared data pin turns output after clock rise, later back; host releases it.
// - Polarity pin low swaps every serial clock edge role.
module acts_core
   import acts_pkg::*;
#(
   parameter int CAL_SELF_LEN = acts_pkg::CAL_SELF_CYCLES,
   parameter int CAL_FS_LEN   = acts_pkg::CAL_FS_CYCLES,
   parameter int CAL_OFF_LEN  = acts_pkg::CAL_OFF_CYCLES,
   parameter int DEPTH        = acts_pkg::FIFO_DEPTH
) (
   input  wire logic                       clk_in,
   input  wire logic                       rst_in,
   input  wire logic                       conversion_start_n_in,
   input  wire logic                       cal_req_in,
   input  wire logic [1:0]                 cal_type_in,
   input  wire logic [2:0]                 interface_mode_in,
   input  wire logic                       polarity_in,
   input  wire logic [acts_pkg::SMP_W-1:0] sample_in,
   input  wire logic                       sclk_in,
   output logic                            sclk_out,
   output logic                            sclk_oe_out,
   input  wire logic                       frame_sync_n_in,
   output logic                            dout_out,
   output logic                            dout_oe_out,
   input  wire logic                       din_in,
   output logic                            din_out,
   output logic                            din_oe_out,
   output logic                            busy_out,
   output logic                            fifo_full_out,
   output logic                            conv_refused_out
);
   import acts_pkg::*;

   function automatic logic is_internal(input logic [2:0] mode);
      is_internal = (mode == MODE_INT_A) || (mode == MODE_INT_B);
   endfunction

   // Counter load: one less than the cycles spent in a state after the edge-detect cycle
   function automatic logic [CNT_W-1:0] first_len(input logic [1:0] ct);
      case (ct)
         CAL_SELF:    first_len = CNT_W'(CAL_SELF_LEN - 2);
         CAL_SYS_FS:  first_len = CNT_W'(CAL_FS_LEN - 2);
         CAL_SYS_OFF: first_len = CNT_W'(CAL_OFF_LEN - 2);
         default:     first_len = CNT_W'(CAL_FS_LEN - 2);
      endcase
   endfunction

   // Master clock side
   logic              start_s1_q;
   logic              start_s2_q;
   logic              start_s3_q;
   logic              cal_s1_q;
   logic              cal_s2_q;
   logic              cal_s3_q;
   logic              frame_s1_q;
   logic              frame_s2_q;
   logic              ack_s1_q;
   logic              ack_s2_q;
   logic [2:0]        mode_s1_q;
   logic [2:0]        mode_s2_q;
   logic              two_wire;
   acts_state_t       state_q;
   logic [CNT_W-1:0]  cnt_q;
   logic [1:0]        cal_type_q;
   logic              start_fall;
   logic              cal_rise;
   logic              start_ok;
   logic              busy_event;
   logic              conv_done;
   logic              conv_refused_q;
   logic              sclk_oe_q;
   logic              gate_q;
   logic              hold_tgl_q;
   logic [SMP_W-1:0]  hold_word_q;
   logic              hold_full;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic [SMP_W-1:0]  fifo_out_data;

   // Link side
   logic              link_clk;
   logic              link_rst;
   logic              hold_l1_q;
   logic              hold_l2_q;
   logic              take_tgl_q;
   logic              started_q;
   logic              pending;
   logic [WORD_W-1:0] shift_q;
   logic [BIT_CNT_W-1:0] rise_cnt_q;
   logic              din_oe_q;

   // Input synchronisers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         start_s1_q <= 1'b1;
         start_s2_q <= 1'b1;
         start_s3_q <= 1'b1;
         cal_s1_q   <= 1'b0;
         cal_s2_q   <= 1'b0;
         cal_s3_q   <= 1'b0;
         frame_s1_q <= 1'b1;
         frame_s2_q <= 1'b1;
         ack_s1_q   <= 1'b0;
         ack_s2_q   <= 1'b0;
         mode_s1_q  <= 3'h0;
         mode_s2_q  <= 3'h0;
      end else begin
         start_s1_q <= conversion_start_n_in;
         start_s2_q <= start_s1_q;
         start_s3_q <= start_s2_q;
         cal_s1_q   <= cal_req_in;
         cal_s2_q   <= cal_s1_q;
         cal_s3_q   <= cal_s2_q;
         frame_s1_q <= frame_sync_n_in;
         frame_s2_q <= frame_s1_q;
         ack_s1_q   <= take_tgl_q;
         ack_s2_q   <= ack_s1_q;
         mode_s1_q  <= interface_mode_in;
         mode_s2_q  <= mode_s1_q;
      end
   end

   assign start_fall = start_s3_q & ~start_s2_q;
   assign cal_rise   = cal_s2_q & ~cal_s3_q;
   // No room for a result means no conversion: the start is refused
   assign start_ok   = start_fall & fifo_in_ready;
   // Mode is static; link clock stops between frames, so it cannot sync mode itself
   assign two_wire   = (mode_s2_q == MODE_TWO_WIRE);

   // Busy rises in the detect cycle itself, two edges after the pin
   assign busy_event = ((state_q == ST_IDLE) & (cal_rise | start_ok))
                     | ((state_q == ST_CAL_WAIT) & start_fall);
   assign busy_out   = busy_event
                     | ((state_q != ST_IDLE) & (state_q != ST_CAL_WAIT));
   assign conv_done  = (state_q == ST_CONVERT) & (cnt_q == '0);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q    <= ST_IDLE;
         cnt_q      <= '0;
         cal_type_q <= CAL_SELF;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (cal_rise) begin
                  cal_type_q <= cal_type_in;
                  cnt_q      <= first_len(cal_type_in);
                  state_q    <= ST_CAL_A;
               end else if (start_ok) begin
                  cnt_q   <= CNT_W'(CONV_CYCLES - 2);
                  state_q <= ST_CONVERT;
               end
            end
            ST_CONVERT: begin
               if (cnt_q == '0) begin
                  state_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            ST_CAL_A: begin
               if (cnt_q == '0) begin
                  // Combined system cal pauses for the host's start edge
                  state_q <= (cal_type_q == CAL_SYS_BOTH) ? ST_CAL_WAIT : ST_IDLE;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            ST_CAL_WAIT: begin
               if (start_fall) begin
                  cnt_q   <= CNT_W'(CAL_OFF_LEN - 2);
                  state_q <= ST_CAL_B;
               end
            end
            ST_CAL_B: begin
               if (cnt_q == '0) begin
                  state_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         conv_refused_q <= 1'b0;
      end else begin
         conv_refused_q <= (state_q == ST_IDLE) & ~cal_rise & start_fall & ~fifo_in_ready;
      end
   end

   assign conv_refused_out = conv_refused_q;
   assign fifo_full_out    = ~fifo_in_ready;

   acts_fifo #(
      .W     (SMP_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .in_valid_in   (conv_done),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (sample_in),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (~hold_full),
      .out_data_out  (fifo_out_data)
   );

   // Hold word is stable while a handover is outstanding
   assign hold_full = hold_tgl_q ^ ack_s2_q;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         hold_tgl_q  <= 1'b0;
         hold_word_q <= '0;
      end else if (fifo_out_valid && !hold_full) begin
         hold_word_q <= fifo_out_data;
         hold_tgl_q  <= ~hold_tgl_q;
      end
   end

   // Serial clock generation for self-clocked modes
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sclk_oe_q <= 1'b0;
      end else begin
         sclk_oe_q <= is_internal(mode_s2_q);
      end
   end

   // Gate changes on the low phase, so the gated clock never glitches
   always_ff @(negedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         gate_q <= 1'b0;
      end else begin
         gate_q <= is_internal(mode_s2_q) & ~frame_s2_q;
      end
   end

   assign sclk_out    = clk_in & gate_q;
   assign sclk_oe_out = sclk_oe_q;

   // Link domain; its clock runs only inside frames, but in modes 4 and 5 gives two more pulses after a frame ends
   assign link_clk = polarity_in ? sclk_in : ~sclk_in;
   assign link_rst = rst_in | frame_sync_n_in;

   always_ff @(negedge link_clk or posedge rst_in) begin
      if (rst_in) begin
         hold_l1_q <= 1'b0;
         hold_l2_q <= 1'b0;
      end else begin
         hold_l1_q <= hold_tgl_q;
         hold_l2_q <= hold_l1_q;
      end
   end

   assign pending = hold_l2_q ^ take_tgl_q;

   // Handover state must outlive the frame, so frame end does not clear it
   always_ff @(negedge link_clk or posedge rst_in) begin
      if (rst_in) begin
         take_tgl_q <= 1'b0;
      // Stray edges outside a frame must not take a word that is never sent
      end else if (!started_q && pending && !frame_sync_n_in) begin
         take_tgl_q <= ~take_tgl_q;
      end
   end

   // Data changes on the falling edge, host samples on the rising one
   always_ff @(negedge link_clk or posedge link_rst) begin
      if (link_rst) begin
         started_q <= 1'b0;
         shift_q   <= '0;
      end else if (!started_q) begin
         started_q          <= 1'b1;
         shift_q            <= {{(WORD_W - SMP_W){1'b0}}, hold_word_q};
         shift_q[FRESH_BIT] <= pending;
      end else begin
         shift_q <= {shift_q[WORD_W-2:0], 1'b0};
      end
   end

   always_ff @(posedge link_clk or posedge link_rst) begin
      if (link_rst) begin
         rise_cnt_q <= '0;
         din_oe_q   <= 1'b0;
      end else begin
         if (rise_cnt_q != BIT_CNT_W'(WORD_W)) begin
            rise_cnt_q <= rise_cnt_q + 1'b1;
         end
         din_oe_q <= two_wire & (rise_cnt_q != BIT_CNT_W'(WORD_W));
      end
   end

   assign dout_out    = shift_q[WORD_W-1];
   assign dout_oe_out = ~frame_sync_n_in & ~two_wire;
   assign din_out     = shift_q[WORD_W-1];
   assign din_oe_out  = din_oe_q & ~frame_sync_n_in;
endmodule // acts_core

// ---- verification/acts_chk.sv ----
`timescale 1ns/1ps
module acts_chk
   import acts_pkg::*;
#(
   parameter int CAL_SELF_LEN = 40,
   parameter int CAL_FS_LEN   = 30,
   parameter int CAL_OFF_LEN  = 20
) (
   input wire logic       clk_in,
   input wire logic       rst_in,
   input wire logic       conversion_start_n_in,
   input wire logic       cal_req_in,
   input wire logic [2:0] interface_mode_in,
   input wire logic       frame_sync_n_in,
   input wire logic       sclk_out,
   input wire logic       dout_oe_out,
   input wire logic       din_oe_out,
   input wire logic       busy_out,
   input wire logic       fifo_full_out,
   input wire logic       conv_refused_out
);
   logic [CNT_W-1:0] busy_len_q;
   logic             int_mode;
   default disable iff (rst_in);
   assign int_mode = interface_mode_in == MODE_INT_A || interface_mode_in == MODE_INT_B;
   // Busy cycles seen so far, cleared between pulses
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) busy_len_q <= '0;
      else busy_len_q <= busy_out ? busy_len_q + 1'b1 : '0;
   end
   conv_start_a: assert property (@(posedge clk_in)
      $fell(conversion_start_n_in) && !busy_out && !cal_req_in && !fifo_full_out |-> ##[1:3] busy_out)
      else $error("no busy after start edge");
   cal_start_a: assert property (@(posedge clk_in)
      $rose(cal_req_in) && !busy_out |-> ##[1:3] busy_out) else $error("no busy after cal request");
   busy_len_a: assert property (@(posedge clk_in)
      $fell(busy_out) |-> busy_len_q inside {CONV_CYCLES, CAL_SELF_LEN, CAL_FS_LEN, CAL_OFF_LEN})
      else $error("busy pulse of wrong length");
   refuse_pulse_a: assert property (@(posedge clk_in)
      conv_refused_out |-> !busy_out && $past(fifo_full_out) ##1 !conv_refused_out)
      else $error("bad refusal pulse");
   sclk_idle_a: assert property (@(negedge clk_in)
      frame_sync_n_in [*4] |-> !sclk_out) else $error("serial clock runs outside frame");
   sclk_run_a: assert property (@(negedge clk_in)
      (!frame_sync_n_in && int_mode) [*4] |-> sclk_out) else $error("serial clock missing in frame");
   dout_oe_a: assert property (@(posedge clk_in)
      dout_oe_out == (!frame_sync_n_in && interface_mode_in != MODE_TWO_WIRE))
      else $error("data output enable wrong");
   din_oe_a: assert property (@(posedge clk_in)
      frame_sync_n_in || interface_mode_in != MODE_TWO_WIRE |-> !din_oe_out)
      else $error("shared pin driven outside frame");
endmodule // acts_chk

bind acts_core acts_chk #(.CAL_SELF_LEN(CAL_SELF_LEN), .CAL_FS_LEN(CAL_FS_LEN), .CAL_OFF_LEN(CAL_OFF_LEN)) i_acts_chk (
   .clk_in(clk_in), .rst_in(rst_in), .conversion_start_n_in(conversion_start_n_in),
   .cal_req_in(cal_req_in), .interface_mode_in(interface_mode_in), .frame_sync_n_in(frame_sync_n_in),
   .sclk_out(sclk_out), .dout_oe_out(dout_oe_out), .din_oe_out(din_oe_out), .busy_out(busy_out),
   .fifo_full_out(fifo_full_out), .conv_refused_out(conv_refused_out));

// ---- verification/acts_host.sv ----
`timescale 1ns/1ps
module acts_host #(
   parameter int HALF_NS = 80
) (
   input  wire logic   sclk_oe_in,
   input  wire logic   sclk_in,
   input  wire logic   pol_in,
   input  wire logic   data_in,
   output logic        sclk_out,
   output logic        frame_sync_n_out,
   output logic        valid_out,
   output logic [15:0] word_out
);
   initial begin
      sclk_out = 1'b1;
      frame_sync_n_out = 1'b1;
      valid_out = 1'b0;
      word_out = 16'h0000;
   end
   // One frame; clock stands still outside it
   task automatic read_word();
      sclk_out <= pol_in;
      #(HALF_NS) frame_sync_n_out <= 1'b0;
      for (int i = 0; i < 17; i++) begin
         // Self-made clock idles low, so its first rise comes before any data
         if (sclk_oe_in) begin
            @(negedge (sclk_in ~^ pol_in));
            @(posedge (sclk_in ~^ pol_in));
         end else begin
            #(HALF_NS) sclk_out <= ~pol_in;
            #(HALF_NS) sclk_out <= pol_in;
            // Shared pin turns round just after the edge
            #(HALF_NS / 2);
         end
         if (i < 16) word_out <= {word_out[14:0], data_in};
      end
      #(HALF_NS) frame_sync_n_out <= 1'b1;
      valid_out <= 1'b1;
      #(HALF_NS) valid_out <= 1'b0;
   endtask
endmodule // acts_host

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import acts_pkg::*;
   localparam int SELF_LEN = 40;
   localparam int FS_LEN   = 30;
   localparam int OFF_LEN  = 20;
   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        start_n = 1'b1;
   logic        cal_req = 1'b0;
   logic [1:0]  cal_type = 2'h0;
   logic [2:0]  mode = 3'h1;
   logic        pol = 1'b1;
   logic [11:0] sample = 12'h000;
   logic        sclk_o, sclk_oe, dout, dout_oe, din_o, din_oe, busy, full, refused, h_sclk, frame_n, h_valid;
   logic [15:0] h_word;
   wire         sclk_w = sclk_oe ? sclk_o : h_sclk;
   // Released line must not show a stale bit
   wire         dout_w = dout_oe ? dout : ~dout;
   wire         din_w = din_oe ? din_o : 1'b0;
   logic [31:0] rng = 32'hB25F;
   int          num_errors = 0;
   int          checked = 0;
   int          refusals = 0;
   int          exp_len[$];
   logic [15:0] exp_word[$];

   acts_core #(.CAL_SELF_LEN(SELF_LEN), .CAL_FS_LEN(FS_LEN), .CAL_OFF_LEN(OFF_LEN), .DEPTH(FIFO_DEPTH)) i_acts_core (
      .clk_in(clk_in), .rst_in(rst_in), .conversion_start_n_in(start_n), .cal_req_in(cal_req),
      .cal_type_in(cal_type), .interface_mode_in(mode), .polarity_in(pol), .sample_in(sample),
      .sclk_in(sclk_w), .sclk_out(sclk_o), .sclk_oe_out(sclk_oe), .frame_sync_n_in(frame_n),
      .dout_out(dout), .dout_oe_out(dout_oe), .din_in(din_w), .din_out(din_o), .din_oe_out(din_oe),
      .busy_out(busy), .fifo_full_out(full), .conv_refused_out(refused));
   acts_host i_acts_host (.sclk_oe_in(sclk_oe), .sclk_in(sclk_w), .pol_in(pol),
      .data_in(mode == MODE_TWO_WIRE ? din_w : dout_w), .sclk_out(h_sclk), .frame_sync_n_out(frame_n),
      .valid_out(h_valid), .word_out(h_word));

   always #25 clk_in = ~clk_in;
   always @(posedge clk_in) if (refused === 1'b1) refusals++;

   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic chk_len(input int got, input int exp);
      checked++;
      if (got != exp) begin
         num_errors++;
         $display("mismatch at %0t: count %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: flag %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checked %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wait_idle();
      repeat (5) @(posedge clk_in);
      for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk_in);
      repeat (3) @(posedge clk_in);
   endtask
   task automatic pulse_start();
      @(posedge clk_in);
      start_n <= 1'b0;
      repeat (3) @(posedge clk_in);
      start_n <= 1'b1;
   endtask
   task automatic convert(input logic twice, input logic taken);
      rng = xs(rng);
      @(posedge clk_in);
      sample <= rng[11:0];
      if (taken) begin
         exp_len.push_back(CONV_CYCLES);
         exp_word.push_back({4'h8, rng[11:0]});
      end
      pulse_start();
      // Second edge lands while busy and must be ignored
      if (twice) pulse_start();
      wait_idle();
   endtask
   // Frames start off the master clock edges; first one may be empty
   task automatic read_all();
      for (int i = 0; i < 24 && exp_word.size() > 0; i++) begin
         repeat (20) @(posedge clk_in);
         #7 i_acts_host.read_word();
      end
      chk_len(exp_word.size(), 0);
   endtask

   initial begin : busy_mon
      int n;
      n = 0;
      forever begin
         @(posedge clk_in);
         if (busy === 1'b1) n++;
         else if (n > 0) begin
            chk_len(n, exp_len.size() > 0 ? exp_len.pop_front() : 0);
            n = 0;
         end
      end
   end
   initial forever begin
      @(posedge h_valid);
      if (h_word[15] !== 1'b0) chk_word(h_word, exp_word.size() > 0 ? exp_word.pop_front() : 16'h0000);
   end
   initial begin
      #1000000;
      num_errors++;
      print_verdict();
   end

   initial begin
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      for (int m = 1; m <= 5; m++) begin
         @(posedge clk_in);
         mode <= 3'(m);
         pol <= m >= 4 || m[0];
         convert(1'b0, 1'b1);
         convert(m == 2, 1'b1);
         read_all();
         $display("mode %0d test done", m);
      end
      // The hold word keeps one result beside the queued ones
      for (int i = 0; i <= FIFO_DEPTH + 1; i++) convert(1'b0, i <= FIFO_DEPTH);
      chk_flag(full, 1'b1);
      chk_len(refusals, 1);
      read_all();
      chk_flag(full, 1'b0);
      $display("full buffer test done");
      for (int t = 0; t < 4; t++) begin
         @(posedge clk_in);
         cal_type <= 2'(t);
         cal_req <= 1'b1;
         exp_len.push_back(t == 0 ? SELF_LEN : t == 2 ? OFF_LEN : FS_LEN);
         repeat (3) @(posedge clk_in);
         cal_req <= 1'b0;
         wait_idle();
         if (t == 3) begin
            exp_len.push_back(OFF_LEN);
            pulse_start();
            wait_idle();
         end
         $display("calibration %0d test done", t);
      end
      chk_len(exp_len.size(), 0);
      print_verdict();
   end
endmodule // tb_top
